//--- logic/fbh_params.svh
// Constants for the flash bus host controller.
// Assumes a 10 MHz core clock; included by bare name.
`ifndef FBH_PARAMS_SVH
`define FBH_PARAMS_SVH
`define FBH_CLK_PERIOD_NS  100
`define FBH_T_ACC_NS       150
`define FBH_T_WP_NS        100
`define FBH_T_RST_NS       200
`define FBH_T_WAKE_NS      400
`define FBH_SYNC_STAGES    2
`define FBH_CYC(ns)        (((ns) + `FBH_CLK_PERIOD_NS - 1) / `FBH_CLK_PERIOD_NS)
`define FBH_CMD_READ_ARRAY 16'h00FF
`define FBH_CMD_READ_ID    16'h0090
`define FBH_CMD_QUERY      16'h0098
`define FBH_CMD_READ_STAT  16'h0070
`define FBH_CMD_ERASE      16'h0020
`define FBH_CMD_PROGRAM    16'h0040
`define FBH_CMD_LOCK       16'h0060
`define FBH_CMD_CONFIRM    16'h00D0
`define FBH_CMD_SUSPEND    16'h00B0
`define FBH_STAT_READY     7
`define FBH_BYTE_MASK      16'h00FF
`endif

//--- logic/fbh_pkg.sv
// Types for the flash bus host controller.
// Used by fbh_ctrl and fbh_cmd_seq with full scoping.
package fbh_pkg;
   typedef enum logic [2:0] {
      FBH_OP_READ    = 3'h0,
      FBH_OP_RDMODE  = 3'h1,
      FBH_OP_ERASE   = 3'h2,
      FBH_OP_PROGRAM = 3'h3,
      FBH_OP_LOCK    = 3'h4,
      FBH_OP_SUSPEND = 3'h5,
      FBH_OP_RESUME  = 3'h6
   } fbh_op_t;
   typedef enum logic [1:0] {
      FBH_RM_ARRAY  = 2'h0,
      FBH_RM_ID     = 2'h1,
      FBH_RM_QUERY  = 2'h2,
      FBH_RM_STATUS = 2'h3
   } fbh_rdmode_t;
   typedef enum logic [7:0] {
      FBH_ST_IDLE  = 8'b0000_0001,
      FBH_ST_WSET  = 8'b0000_0010,
      FBH_ST_WPUL  = 8'b0000_0100,
      FBH_ST_WEND  = 8'b0000_1000,
      FBH_ST_RSET  = 8'b0001_0000,
      FBH_ST_RWAIT = 8'b0010_0000,
      FBH_ST_RST   = 8'b0100_0000,
      FBH_ST_WAKE  = 8'b1000_0000
   } fbh_state_t;
endpackage

//--- logic/fbh_cmd_seq.sv
// Command sequencer: turns a host operation into one or two bus write words.
// Assumes the caller holds op and data steady while busy in fbh_ctrl.
`timescale 1ns/10ps
`include "fbh_params.svh"
module fbh_cmd_seq (
   // Request
   input  wire fbh_pkg::fbh_op_t     op_i,
   input  wire fbh_pkg::fbh_rdmode_t rdmode_i,
   input  wire logic [15:0]          wdata_i,
   input  wire logic                 step_i,
   // Result
   output logic [15:0]               word_o,
   output logic                      last_o
);
   function automatic logic [15:0] mode_cmd(input fbh_pkg::fbh_rdmode_t m);
      case (m)
         fbh_pkg::FBH_RM_ID:     mode_cmd = `FBH_CMD_READ_ID;
         fbh_pkg::FBH_RM_QUERY:  mode_cmd = `FBH_CMD_QUERY;
         fbh_pkg::FBH_RM_STATUS: mode_cmd = `FBH_CMD_READ_STAT;
         default:                mode_cmd = `FBH_CMD_READ_ARRAY;
      endcase
   endfunction

   always_comb begin
      last_o = step_i;
      case (op_i)
         fbh_pkg::FBH_OP_ERASE:   word_o = step_i ? `FBH_CMD_CONFIRM : `FBH_CMD_ERASE;
         fbh_pkg::FBH_OP_PROGRAM: word_o = step_i ? wdata_i : `FBH_CMD_PROGRAM;
         fbh_pkg::FBH_OP_LOCK:    word_o = step_i ? wdata_i : `FBH_CMD_LOCK;
         fbh_pkg::FBH_OP_SUSPEND: begin
            word_o = `FBH_CMD_SUSPEND;
            last_o = 1'b1;
         end
         fbh_pkg::FBH_OP_RESUME: begin
            word_o = `FBH_CMD_CONFIRM;
            last_o = 1'b1;
         end
         default: begin
            word_o = mode_cmd(rdmode_i);
            last_o = 1'b1;
         end
      endcase
   end
endmodule

//--- logic/fbh_ctrl.sv
// Host controller that drives an asynchronous parallel flash over its pins.
// Assumes one 10 MHz clock; the flash's ready/busy line arrives asynchronously.
`timescale 1ns/10ps
`include "fbh_params.svh"
module fbh_ctrl #(
   parameter int ADDR_W = 22
) (
   // Clock and reset
   input  wire logic                 core_clk_i,
   input  wire logic                 rstn_i,
   // Host request
   input  wire logic                 req_i,
   input  wire fbh_pkg::fbh_op_t     op_i,
   input  wire fbh_pkg::fbh_rdmode_t rdmode_i,
   input  wire logic [ADDR_W-1:0]    addr_i,
   input  wire logic [15:0]          wdata_i,
   input  wire logic                 byte_mode_i,
   input  wire logic                 powerdown_i,
   // Host answer
   output logic                      busy_o,
   output logic                      done_o,
   output logic [15:0]               rdata_o,
   output logic                      flash_ready_o,
   // Flash pins
   output logic [ADDR_W-1:0]         flash_addr_o,
   output logic                      chip_select_a_n_o,
   output logic                      chip_select_b_n_o,
   output logic                      output_enable_n_o,
   output logic                      write_enable_n_o,
   output logic                      reset_powerdown_n_o,
   output logic                      byte_select_n_o,
   output logic [15:0]               flash_dq_o,
   output logic                      flash_dq_oe_n_o,
   input  wire logic [15:0]          flash_dq_i,
   input  wire logic                 flash_ready_i
);
   localparam logic [3:0] ACC_CYC  = 4'(`FBH_CYC(`FBH_T_ACC_NS));
   localparam logic [3:0] WP_CYC   = 4'(`FBH_CYC(`FBH_T_WP_NS));
   localparam logic [3:0] RST_CYC  = 4'(`FBH_CYC(`FBH_T_RST_NS));
   localparam logic [3:0] WAKE_CYC = 4'(`FBH_CYC(`FBH_T_WAKE_NS));
   localparam logic [3:0] SYNC_CYC = 4'(`FBH_SYNC_STAGES);

   if (ADDR_W < 1 || ADDR_W > 32) begin : g_bad_addr_w
      $error("ADDR_W out of range");
   end

   fbh_pkg::fbh_state_t  state, next_state;
   fbh_pkg::fbh_op_t     op, next_op;
   fbh_pkg::fbh_rdmode_t mode, next_mode;
   logic [3:0]           cnt, next_cnt;
   logic                 step, next_step;
   logic [ADDR_W-1:0]    addr, next_addr;
   logic [15:0]          wdata, next_wdata;
   logic [15:0]          rdata, next_rdata;
   logic                 byte_n, next_byte_n;
   logic                 done, next_done;
   logic                 ce_n, next_ce_n;
   logic                 oe_n, next_oe_n;
   logic                 we_n, next_we_n;
   logic                 rp_n, next_rp_n;
   logic                 dq_oe_n, next_dq_oe_n;
   logic [15:0]          dq_out, next_dq_out;
   logic                 rdy_s1, rdy_s2;
   logic [15:0]          dq_s1, dq_s2;
   logic [15:0]          seq_word;
   logic                 seq_last;

   fbh_cmd_seq u_seq (
      .op_i     (op),
      .rdmode_i (mode),
      .wdata_i  (wdata),
      .step_i   (step),
      .word_o   (seq_word),
      .last_o   (seq_last)
   );

   always_comb begin
      next_state     = state;
      next_op        = op;
      next_mode      = mode;
      next_cnt       = cnt;
      next_step      = step;
      next_addr      = addr;
      next_wdata     = wdata;
      next_rdata     = rdata;
      next_byte_n    = byte_n;
      next_done      = 1'b0;
      next_ce_n      = ce_n;
      next_oe_n      = oe_n;
      next_we_n      = we_n;
      next_rp_n      = rp_n;
      next_dq_oe_n   = dq_oe_n;
      next_dq_out    = dq_out;
      case (state)
         fbh_pkg::FBH_ST_IDLE: begin
            next_ce_n    = 1'b1;
            next_oe_n    = 1'b1;
            next_we_n    = 1'b1;
            next_dq_oe_n = 1'b1;
            if (powerdown_i) begin
               next_rp_n  = 1'b0;
               next_cnt   = RST_CYC;
               next_state = fbh_pkg::FBH_ST_RST;
            end else if (req_i) begin
               next_op        = op_i;
               next_addr      = addr_i;
               next_wdata     = wdata_i;
               next_byte_n    = ~byte_mode_i;
               next_step      = 1'b0;
               if (op_i == fbh_pkg::FBH_OP_RDMODE) begin
                  next_mode = rdmode_i;
               end else if (op_i == fbh_pkg::FBH_OP_ERASE || op_i == fbh_pkg::FBH_OP_PROGRAM
                            || op_i == fbh_pkg::FBH_OP_LOCK) begin
                  // The flash answers status until told otherwise.
                  next_mode = fbh_pkg::FBH_RM_STATUS;
               end
               if (op_i == fbh_pkg::FBH_OP_READ) begin
                  next_state = fbh_pkg::FBH_ST_RSET;
               end else begin
                  next_state = fbh_pkg::FBH_ST_WSET;
               end
            end
         end
         fbh_pkg::FBH_ST_WSET: begin
            // Output enable stays high for the whole write cycle.
            next_oe_n    = 1'b1;
            next_ce_n    = 1'b0;
            next_dq_oe_n = 1'b0;
            next_dq_out  = seq_word;
            next_state   = fbh_pkg::FBH_ST_WPUL;
            next_we_n    = 1'b0;
            next_cnt     = WP_CYC;
         end
         fbh_pkg::FBH_ST_WPUL: begin
            if (cnt > 4'h1) begin
               next_cnt = cnt - 4'h1;
            end else begin
               // Strobe rises before chip select, so the strobe edge latches.
               next_we_n  = 1'b1;
               next_state = fbh_pkg::FBH_ST_WEND;
            end
         end
         fbh_pkg::FBH_ST_WEND: begin
            next_ce_n    = 1'b1;
            next_dq_oe_n = 1'b1;
            if (seq_last) begin
               next_done  = 1'b1;
               next_state = fbh_pkg::FBH_ST_IDLE;
            end else begin
               next_step  = 1'b1;
               next_state = fbh_pkg::FBH_ST_WSET;
            end
         end
         fbh_pkg::FBH_ST_RSET: begin
            next_ce_n    = 1'b0;
            next_oe_n    = 1'b0;
            next_we_n    = 1'b1;
            next_dq_oe_n = 1'b1;
            // The data bus passes two flip-flops, so output enable stays low that much longer.
            next_cnt     = ACC_CYC + SYNC_CYC;
            next_state   = fbh_pkg::FBH_ST_RWAIT;
         end
         fbh_pkg::FBH_ST_RWAIT: begin
            if (cnt > 4'h1) begin
               next_cnt = cnt - 4'h1;
            end else begin
               // In byte mode the upper lines are not driven by the flash.
               next_rdata = !byte_n ? (dq_s2 & `FBH_BYTE_MASK) : dq_s2;
               next_ce_n  = 1'b1;
               next_oe_n  = 1'b1;
               next_done  = 1'b1;
               next_state = fbh_pkg::FBH_ST_IDLE;
            end
         end
         fbh_pkg::FBH_ST_RST: begin
            if (cnt > 4'h1) begin
               next_cnt = cnt - 4'h1;
            end else if (!powerdown_i) begin
               next_rp_n  = 1'b1;
               next_cnt   = WAKE_CYC;
               next_state = fbh_pkg::FBH_ST_WAKE;
            end
         end
         fbh_pkg::FBH_ST_WAKE: begin
            if (cnt > 4'h1) begin
               next_cnt = cnt - 4'h1;
            end else begin
               next_mode  = fbh_pkg::FBH_RM_ARRAY;
               next_state = fbh_pkg::FBH_ST_IDLE;
            end
         end
         default: next_state = fbh_pkg::FBH_ST_IDLE;
      endcase
   end

   always_ff @(posedge core_clk_i) begin
      if (!rstn_i) begin
         state     <= fbh_pkg::FBH_ST_IDLE;
         op        <= fbh_pkg::FBH_OP_READ;
         mode      <= fbh_pkg::FBH_RM_ARRAY;
         cnt       <= 4'h0;
         step      <= 1'b0;
         addr      <= '0;
         wdata     <= 16'h0000;
         rdata     <= 16'h0000;
         byte_n    <= 1'b1;
         done      <= 1'b0;
         ce_n      <= 1'b1;
         oe_n      <= 1'b1;
         we_n      <= 1'b1;
         rp_n      <= 1'b1;
         dq_oe_n   <= 1'b1;
         dq_out    <= 16'h0000;
         rdy_s1    <= 1'b0;
         rdy_s2    <= 1'b0;
         dq_s1     <= 16'h0000;
         dq_s2     <= 16'h0000;
      end else begin
         state     <= next_state;
         op        <= next_op;
         mode      <= next_mode;
         cnt       <= next_cnt;
         step      <= next_step;
         addr      <= next_addr;
         wdata     <= next_wdata;
         rdata     <= next_rdata;
         byte_n    <= next_byte_n;
         done      <= next_done;
         ce_n      <= next_ce_n;
         oe_n      <= next_oe_n;
         we_n      <= next_we_n;
         rp_n      <= next_rp_n;
         dq_oe_n   <= next_dq_oe_n;
         dq_out    <= next_dq_out;
         rdy_s1    <= flash_ready_i;
         rdy_s2    <= rdy_s1;
         dq_s1     <= flash_dq_i;
         dq_s2     <= dq_s1;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!rstn_i) begin
         busy_o <= 1'b0;
      end else begin
         busy_o <= (next_state != fbh_pkg::FBH_ST_IDLE);
      end
   end

   assign done_o              = done;
   assign rdata_o             = rdata;
   assign flash_ready_o       = rdy_s2;
   assign flash_addr_o        = addr;
   assign chip_select_a_n_o   = ce_n;
   assign chip_select_b_n_o   = ce_n;
   assign output_enable_n_o   = oe_n;
   assign write_enable_n_o    = we_n;
   assign reset_powerdown_n_o = rp_n;
   assign byte_select_n_o     = byte_n;
   assign flash_dq_o          = dq_out;
   assign flash_dq_oe_n_o     = dq_oe_n;
endmodule

//--- bench/fbh_flash_model.sv
// Behavioural model of the parallel flash on the far side of fbh_ctrl.
// Assumes the bench resolves the shared data bus and feeds it to dq_i.
`timescale 1ns/10ps
module fbh_flash_model #(
   parameter logic [15:0] ID_CODE  = 16'h5A3C, // Arbitrary identifier value.
   parameter logic [15:0] QRY_CODE = 16'h0051,
   parameter int          BUSY_CYC = 40
) (
   // Bus pins
   input  wire logic        core_clk_i,
   input  wire logic [3:0]  addr_i,
   input  wire logic        cs_a_n_i,
   input  wire logic        cs_b_n_i,
   input  wire logic        oe_n_i,
   input  wire logic        we_n_i,
   input  wire logic        rp_n_i,
   input  wire logic        byte_n_i,
   input  wire logic        vpp_ok_i,
   input  wire logic [15:0] dq_i,
   // Flash answers
   output logic [15:0]      dq_o,
   output logic             ready_o
);
   logic [15:0] mem [16];
   logic [15:0] dout;
   logic [15:0] idle_q;
   logic [15:0] pd;
   logic [7:0]  first;
   logic [7:0]  pend;
   logic [3:0]  pa;
   logic [1:0]  mode;
   logic        susp;
   logic        verr;
   int          cnt;
   wire sel = !cs_a_n_i && !cs_b_n_i && rp_n_i;
   wire wr  = sel && !we_n_i && oe_n_i;
   wire rd  = sel && !oe_n_i && we_n_i;
   wire [7:0] stat = {ready_o, susp, 2'b00, verr, 3'b000};
   assign ready_o = (cnt == 0) || susp;
   initial begin
      foreach (mem[i]) mem[i] = 16'hFFFF;
      idle_q = 16'h0F0F;
      first = 8'h00;
      cnt = 0;
      susp = 1'b0;
      verr = 1'b0;
      mode = 2'd0;
   end
   // Address and data are taken when the write strobe or a select is released.
   always @(negedge wr) begin
      if (first != 8'h00) begin
         verr = !vpp_ok_i;
         if (vpp_ok_i) begin
            pend = first;
            pa = addr_i;
            pd = dq_i;
            cnt = BUSY_CYC;
         end
         first = 8'h00;
         mode = 2'd3;
      end else begin
         case (dq_i[7:0])
            8'hFF: mode = 2'd0;
            8'h90: mode = 2'd1;
            8'h98: mode = 2'd2;
            8'h70: mode = 2'd3;
            8'h20, 8'h40, 8'h60: first = dq_i[7:0];
            8'hB0: begin
               susp = (cnt != 0);
               mode = 2'd3;
            end
            8'hD0: susp = 1'b0;
            default: ;
         endcase
      end
   end
   // The alteration lands only at completion, so suspended reads see old data.
   always @(posedge core_clk_i) begin
      idle_q <= ~idle_q;
      if (!rp_n_i) begin
         mode = 2'd0;
         cnt = 0;
         susp = 1'b0;
         first = 8'h00;
         verr = 1'b0;
      end else if (cnt > 0 && !susp) begin
         if (cnt == 1 && pend == 8'h40) mem[pa] = pd;
         if (cnt == 1 && pend == 8'h20) foreach (mem[i]) mem[i] = 16'hFFFF;
         cnt = cnt - 1;
      end
   end
   always @* begin
      case (mode)
         2'd0: dout = mem[addr_i];
         2'd1: dout = ID_CODE;
         2'd2: dout = QRY_CODE;
         default: dout = {8'h00, stat};
      endcase
      if (cnt != 0 && !susp) dout = {8'h00, stat};
   end
   assign dq_o = rd ? {byte_n_i ? dout[15:8] : idle_q[15:8], dout[7:0]} : idle_q;
endmodule

//--- bench/fbh_ctrl_chk_chk.sv
// Pin-level checker for fbh_ctrl, bound to every instance of it.
// Assumes the single core clock and synchronous active-low reset.
`timescale 1ns/10ps
module fbh_ctrl_chk (
   // Clock and reset
   input wire logic        core_clk_i,
   input wire logic        rstn_i,
   // Observed outputs
   input wire logic        done_o,
   input wire logic [15:0] rdata_o,
   input wire logic        chip_select_a_n_o,
   input wire logic        chip_select_b_n_o,
   input wire logic        output_enable_n_o,
   input wire logic        write_enable_n_o,
   input wire logic        reset_powerdown_n_o,
   input wire logic        byte_select_n_o,
   input wire logic [15:0] flash_dq_o,
   input wire logic        flash_dq_oe_n_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rstn_i);
   a_strobe_excl: assert property (output_enable_n_o || write_enable_n_o)
      else $error("Output and write strobes low together.");
   a_cs_pair: assert property (chip_select_a_n_o == chip_select_b_n_o)
      else $error("Chip selects differ.");
   a_read_sel: assert property (!output_enable_n_o |-> !chip_select_a_n_o &&
      write_enable_n_o && reset_powerdown_n_o && flash_dq_oe_n_o)
      else $error("Bad pin state during read.");
   a_write_oe: assert property (!write_enable_n_o |-> output_enable_n_o &&
      !chip_select_a_n_o && !flash_dq_oe_n_o && reset_powerdown_n_o)
      else $error("Bad pin state during write.");
   a_read_len: assert property ($fell(output_enable_n_o) |=>
      !output_enable_n_o[*3] ##1 (output_enable_n_o && done_o))
      else $error("Read cycle length wrong.");
   a_we_pulse: assert property ($fell(write_enable_n_o) |=>
      write_enable_n_o ##1 (chip_select_a_n_o && flash_dq_oe_n_o))
      else $error("Write pulse shape wrong.");
   a_data_hold: assert property ($rose(write_enable_n_o) |-> $stable(flash_dq_o) &&
      !chip_select_a_n_o && !flash_dq_oe_n_o)
      else $error("Write data not held at strobe release.");
   a_byte_upper: assert property (done_o && !$past(output_enable_n_o) &&
      !byte_select_n_o |-> rdata_o[15:8] == 8'h00)
      else $error("Upper byte not zero in byte mode.");
   a_wake_quiet: assert property ($rose(reset_powerdown_n_o) |-> chip_select_a_n_o[*4])
      else $error("Access too soon after wake.");
endmodule
bind fbh_ctrl fbh_ctrl_chk u_chk (
   .core_clk_i(core_clk_i), .rstn_i(rstn_i), .done_o(done_o), .rdata_o(rdata_o),
   .chip_select_a_n_o(chip_select_a_n_o), .chip_select_b_n_o(chip_select_b_n_o),
   .output_enable_n_o(output_enable_n_o), .write_enable_n_o(write_enable_n_o),
   .reset_powerdown_n_o(reset_powerdown_n_o), .byte_select_n_o(byte_select_n_o),
   .flash_dq_o(flash_dq_o), .flash_dq_oe_n_o(flash_dq_oe_n_o));

//--- bench/test_fbh_ctrl.sv
// Self-checking bench for fbh_ctrl against the flash model.
// Assumes the design package and header compile first.
`timescale 1ns/10ps
module test_fbh_ctrl;
   logic core_clk, rstn, req, byte_mode, powerdown, vpp_ok, rd_op;
   fbh_pkg::fbh_op_t op;
   fbh_pkg::fbh_rdmode_t rdmode;
   logic [21:0] addr, f_addr;
   logic [15:0] wdata, rdata, dq_o, mdl_q, d, r;
   logic [15:0] tbl [4];
   logic busy, done, rdy, cs_a_n, cs_b_n, oe_n, we_n, rp_n, byte_n, dq_oe_n, m_rdy;
   wire  [15:0] dq_bus = !dq_oe_n ? dq_o : mdl_q;
   logic [15:0] exp_q [$];
   int failures, checked, seed, cyc, n;
   fbh_ctrl DUT (.core_clk_i(core_clk), .rstn_i(rstn), .req_i(req), .op_i(op),
      .rdmode_i(rdmode), .addr_i(addr), .wdata_i(wdata), .byte_mode_i(byte_mode),
      .powerdown_i(powerdown), .busy_o(busy), .done_o(done), .rdata_o(rdata),
      .flash_ready_o(rdy), .flash_addr_o(f_addr), .chip_select_a_n_o(cs_a_n),
      .chip_select_b_n_o(cs_b_n), .output_enable_n_o(oe_n), .write_enable_n_o(we_n),
      .reset_powerdown_n_o(rp_n), .byte_select_n_o(byte_n), .flash_dq_o(dq_o),
      .flash_dq_oe_n_o(dq_oe_n), .flash_dq_i(dq_bus), .flash_ready_i(m_rdy));
   fbh_flash_model u_flash (.core_clk_i(core_clk), .addr_i(f_addr[3:0]), .cs_a_n_i(cs_a_n),
      .cs_b_n_i(cs_b_n), .oe_n_i(oe_n), .we_n_i(we_n), .rp_n_i(rp_n), .byte_n_i(byte_n),
      .vpp_ok_i(vpp_ok), .dq_i(dq_bus), .dq_o(mdl_q), .ready_o(m_rdy));
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   task automatic conclude;
      if (failures == 0 && checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic run(input fbh_pkg::fbh_op_t o, input fbh_pkg::fbh_rdmode_t m,
                      input logic [21:0] a, input logic [15:0] w, input logic b);
      @(posedge core_clk);
      rd_op = (o == fbh_pkg::FBH_OP_READ);
      op <= o;
      rdmode <= m;
      addr <= a;
      wdata <= w;
      byte_mode <= b;
      req <= 1'b1;
      @(posedge core_clk);
      req <= 1'b0;
      for (n = 0; n < 40 && done !== 1'b1; n++) @(posedge core_clk);
   endtask
   task automatic rd(input logic [21:0] a, input logic b, input logic [15:0] e);
      exp_q.push_back(e);
      run(fbh_pkg::FBH_OP_READ, fbh_pkg::FBH_RM_ARRAY, a, 16'h0000, b);
   endtask
   task automatic mode(input fbh_pkg::fbh_rdmode_t m);
      run(fbh_pkg::FBH_OP_RDMODE, m, 22'h00_0000, 16'h0000, 1'b0);
   endtask
   task automatic wait_rdy;
      repeat (3) @(posedge core_clk);
      for (n = 0; n < 300 && (rdy !== 1'b1 || busy !== 1'b0); n++) @(posedge core_clk);
   endtask
   task automatic cmp(input logic [15:0] got, input logic [15:0] e);
      checked++;
      if (got !== e) begin
         failures++;
         $display("[ERR] %0t read data %h, expected %h", $time, got, e);
      end
   endtask
   // Results are paired with notes in issue order; only reads produce one.
   always @(posedge core_clk) begin
      cyc++;
      if (done === 1'b1 && rd_op) cmp(rdata, exp_q.pop_front());
      if (cyc == 6000) begin
         failures++;
         conclude();
      end
   end
   initial begin
      seed = 19;
      {rstn, req, byte_mode, powerdown, rd_op} = 5'b00000;
      vpp_ok = 1'b1;
      op = fbh_pkg::FBH_OP_READ;
      rdmode = fbh_pkg::FBH_RM_ARRAY;
      addr = 22'h00_0000;
      wdata = 16'h0000;
      repeat (5) @(posedge core_clk);
      rstn <= 1'b1;
      d = 16'($random(seed));
      rd(22'h00_0003, 1'b0, 16'hFFFF);
      run(fbh_pkg::FBH_OP_PROGRAM, fbh_pkg::FBH_RM_ARRAY, 22'h00_0005, d, 1'b0);
      rd(22'h00_0009, 1'b0, 16'h0000);
      wait_rdy();
      rd(22'h00_0005, 1'b0, 16'h0080);
      tbl = '{d, 16'h5A3C, 16'h0051, 16'h0080};
      for (int m = 0; m < 4; m++) begin
         mode(fbh_pkg::fbh_rdmode_t'(m));
         rd(22'h00_0005, 1'b0, tbl[m]);
         rd(22'h00_0005, 1'b1, {8'h00, tbl[m][7:0]});
      end
      vpp_ok <= 1'b0;
      run(fbh_pkg::FBH_OP_PROGRAM, fbh_pkg::FBH_RM_ARRAY, 22'h00_0006, ~d, 1'b0);
      wait_rdy();
      rd(22'h00_0006, 1'b0, 16'h0088);
      mode(fbh_pkg::FBH_RM_ARRAY);
      rd(22'h00_0006, 1'b0, 16'hFFFF);
      vpp_ok <= 1'b1;
      run(fbh_pkg::FBH_OP_LOCK, fbh_pkg::FBH_RM_ARRAY, 22'h00_0000, 16'h0001, 1'b0);
      wait_rdy();
      rd(22'h00_0000, 1'b0, 16'h0080);
      run(fbh_pkg::FBH_OP_ERASE, fbh_pkg::FBH_RM_ARRAY, 22'h00_0000, 16'h0000, 1'b0);
      run(fbh_pkg::FBH_OP_SUSPEND, fbh_pkg::FBH_RM_ARRAY, 22'h00_0000, 16'h0000, 1'b0);
      rd(22'h00_0000, 1'b0, 16'h00C0);
      mode(fbh_pkg::FBH_RM_ARRAY);
      rd(22'h00_0005, 1'b0, d);
      run(fbh_pkg::FBH_OP_RESUME, fbh_pkg::FBH_RM_ARRAY, 22'h00_0000, 16'h0000, 1'b0);
      wait_rdy();
      mode(fbh_pkg::FBH_RM_ARRAY);
      rd(22'h00_0005, 1'b0, 16'hFFFF);
      run(fbh_pkg::FBH_OP_PROGRAM, fbh_pkg::FBH_RM_ARRAY, 22'h00_0005, 16'h1234, 1'b0);
      run(fbh_pkg::FBH_OP_SUSPEND, fbh_pkg::FBH_RM_ARRAY, 22'h00_0000, 16'h0000, 1'b0);
      mode(fbh_pkg::FBH_RM_ARRAY);
      rd(22'h00_0007, 1'b0, 16'hFFFF);
      run(fbh_pkg::FBH_OP_RESUME, fbh_pkg::FBH_RM_ARRAY, 22'h00_0000, 16'h0000, 1'b0);
      wait_rdy();
      mode(fbh_pkg::FBH_RM_ID);
      @(posedge core_clk);
      powerdown <= 1'b1;
      repeat (6) @(posedge core_clk);
      powerdown <= 1'b0;
      wait_rdy();
      rd(22'h00_0005, 1'b0, 16'h1234);
      mode(fbh_pkg::FBH_RM_STATUS);
      rd(22'h00_0000, 1'b0, 16'h0080);
      mode(fbh_pkg::FBH_RM_ARRAY);
      repeat (6) begin
         r = 16'($random(seed));
         d = (r[3:0] == 4'h5) ? 16'h1234 : 16'hFFFF;
         rd({r[15:4], 6'h00, r[3:0]}, r[4], r[4] ? {8'h00, d[7:0]} : d);
      end
      repeat (2) @(posedge core_clk);
      conclude();
   end
endmodule
